// file: design/gkid_deb_if.sv
// Interface between the top and one debounce detector
`timescale 1ns/1ns
interface gkid_deb_if;
    logic cond;
    logic en;
    logic tick;
    logic [gkid_pkg::MS_W-1:0] ms;
    logic level;
    logic rise;
    logic fall;
    modport ctl (output cond, output en, output tick, output ms,
                 input level, input rise, input fall);
    modport det (input cond, input en, input tick, input ms,
                 output level, output rise, output fall);
endinterface

// file: design/gkid_debounce.sv
// Debounce detector: level follows a condition after a stable time
`timescale 1ns/1ns
module gkid_debounce (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    gkid_deb_if.det d
);
    logic lvl_r;
    logic lvl_nxt;
    logic rise_r;
    logic fall_r;
    logic [gkid_pkg::MS_W-1:0] cnt_r;
    logic [gkid_pkg::MS_W-1:0] cnt_nxt;
    wire differ = d.cond != lvl_r;
    wire bypass = !d.en || d.ms == '0;
    wire expire = ({1'b0, cnt_r} + 7'h01) >= {1'b0, d.ms};

    // Any return to the old level restarts the count
    always_comb begin
        lvl_nxt = lvl_r;
        cnt_nxt = cnt_r;
        if (!differ) begin
            cnt_nxt = '0;
        end else if (bypass) begin
            lvl_nxt = d.cond;
            cnt_nxt = '0;
        end else if (d.tick) begin
            if (expire) begin
                lvl_nxt = d.cond;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
    end

    // Level and one-cycle edge pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_r <= 1'b0;
            cnt_r <= '0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else if (ce_i) begin
            lvl_r <= lvl_nxt;
            cnt_r <= cnt_nxt;
            rise_r <= lvl_nxt & ~lvl_r;
            fall_r <= lvl_r & ~lvl_nxt;
        end
    end

    assign d.level = lvl_r;
    assign d.rise = rise_r;
    assign d.fall = fall_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    deb_gate_tick_a: assert property (
        ce_i && d.en && d.ms != '0 && !d.tick |=> $stable(lvl_r))
        else $error("debounced level moved without a tick");
    deb_restart_a: assert property (
        ce_i && !differ |=> cnt_r == '0)
        else $error("debounce count not restarted");
endmodule // gkid_debounce

// file: design/gkid_irq_top.sv
// Top: pin and keypad interrupt channels behind a Wishbone slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
// Functional notes
// - Per-channel debounce enables in bits 12:8
// - Keypad debounce enable at bit 13
// - Keypad interrupt after N ms debounce
// - Channel clear bits 4:0, read zero
// - Keypad clear at bit 5, reads zero
// - Wait bit zero: re-interrupt right after clear
// - Wait bit one: need inactive input first
// - Channel polarity: zero high, one low
// - Optional keypad interrupt on key release
// - Keypad polarity bit 14, one means low
// - Auto-repeat every N ms while pressed
// - Repeat value zero disables the timer
// - Port 0 pin enables feed keypad
// - Six-bit pin selector, zero selects none
module gkid_irq_top #(
    parameter int TICK_CYCLES = gkid_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [gkid_pkg::N_PINS-1:0] pin_i,
    output logic [gkid_pkg::N_CH-1:0] channel_irq_o,
    output logic keypad_interrupt_o
);
    localparam int NC = gkid_pkg::N_CH;
    localparam int NK = gkid_pkg::N_KEYS;

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be,
                                            input logic [15:0] msk);
        logic [15:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & msk;
    endfunction

    // Pin picked by a selector code; codes 1..32 map to pins 0..31
    function automatic logic pick_pin(input logic [31:0] p,
                                      input logic [5:0] code);
        logic hit;
        hit = 1'b0;
        for (int k = 1; k <= 32; k++) begin
            if (code == 6'(k)) begin
                hit = p[k-1];
            end
        end
        return hit;
    endfunction

    // Registers
    logic [15:0] deb_r;
    logic [15:0] lvl_r;
    logic [15:0] key_r;
    logic [5:0] sel_r [NC];
    logic [NC-1:0] pend_r;
    logic [NC-1:0] pend_nxt;
    logic [NC-1:0] blk_r;
    logic [NC-1:0] blk_nxt;
    logic kpend_r;
    logic kpend_nxt;
    logic [5:0] rep_r;
    logic [5:0] rep_nxt;
    logic [31:0] tick_r;
    logic [31:0] dat_r;
    gkid_pkg::gkid_wb_t st_r;
    gkid_pkg::gkid_wb_t st_nxt;
    logic [gkid_pkg::N_PINS-1:0] pin_s;
    logic [15:0] sel_rd;
    logic [NC-1:0] hit_sel;
    logic [NC-1:0] chan_cond;
    logic [NC-1:0] dlev;
    logic [NC-1:0] drise;

    // Pins come from outside the clock domain
    gkid_sync #(.W(gkid_pkg::N_PINS)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(pin_i),
        .q_o(pin_s)
    );

    // Bus decode; the slave answers one cycle after the request
    wire [5:0] widx = wb_adr_i[7:2];
    wire acc = ce_i && wb_cyc_i && wb_stb_i && st_r == gkid_pkg::GKID_WB_IDLE;
    wire wr = acc && wb_we_i;
    wire hit_deb = widx == gkid_pkg::DEB_WI;
    wire hit_clr = widx == gkid_pkg::CLR_WI;
    wire hit_lvl = widx == gkid_pkg::LVL_WI;
    wire hit_key = widx == gkid_pkg::KEY_WI;
    wire hit_stat = widx == gkid_pkg::STAT_WI;
    wire clr_wr = wr && hit_clr && wb_sel_i[0];

    // Control fields
    wire [5:0] deb_ms = deb_r[gkid_pkg::DEB_VAL_LSB +: 6];
    wire [NC-1:0] deb_ch_on = deb_r[gkid_pkg::DEB_CH_LSB +: NC];
    wire deb_key_on = deb_r[gkid_pkg::DEB_KEY_BIT];
    wire [NC-1:0] ch_low = lvl_r[gkid_pkg::LOW_LSB +: NC];
    wire [NC-1:0] ch_wait = lvl_r[gkid_pkg::WAIT_LSB +: NC];
    wire [NK-1:0] key_en = key_r[gkid_pkg::KEN_LSB +: NK];
    wire [5:0] rep_ms = key_r[gkid_pkg::REP_LSB +: 6];
    wire key_low = key_r[gkid_pkg::KLOW_BIT];
    wire key_rel = key_r[gkid_pkg::REL_BIT];
    wire [NC-1:0] clr_ch = clr_wr ? wb_dat_i[NC-1:0] : '0;
    wire kclr = clr_wr && wb_dat_i[gkid_pkg::CLR_KEY_BIT];

    // Millisecond tick shared by every timer; it runs free, so a timer
    // may end up to one tick early, as its first tick can come at any phase
    wire tick = ce_i && tick_r == 32'(TICK_CYCLES - 1);

    // Keypad condition: any enabled port 0 pin at its active level
    wire [NK-1:0] key_act = key_en & (pin_s[NK-1:0] ^ {NK{key_low}});
    wire kcond = |key_act;

    // One debounce detector per channel plus one for the keypad
    gkid_deb_if dif [NC+1] ();

    genvar gi;
    generate
        for (gi = 0; gi < NC + 1; gi++) begin : g_deb
            gkid_debounce u_deb (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .d(dif[gi])
            );
            assign dif[gi].tick = tick;
            assign dif[gi].ms = deb_ms;
        end
        for (gi = 0; gi < NC; gi++) begin : g_ch
            // Unassigned codes pick nothing, so polarity cannot fire them
            wire valid = sel_r[gi] != 6'h00 && sel_r[gi] <= 6'h20;
            assign chan_cond[gi] = valid && (pick_pin(pin_s, sel_r[gi]) ^ ch_low[gi]);
            assign dif[gi].cond = chan_cond[gi];
            assign dif[gi].en = deb_ch_on[gi];
            assign dlev[gi] = dif[gi].level;
            assign drise[gi] = dif[gi].rise;
            assign hit_sel[gi] = widx == 6'(gkid_pkg::SEL0_WI + 2 * gi);
        end
    endgenerate

    assign dif[NC].cond = kcond;
    assign dif[NC].en = deb_key_on;
    wire klev = dif[NC].level;
    wire krise = dif[NC].rise;
    wire kfall = dif[NC].fall;

    // Channel pending: set wins, except a clear under wait blocks
    // the still-active level until the input goes inactive
    wire [NC-1:0] hold = clr_ch & ch_wait & ~drise;
    assign pend_nxt = (dlev & ~blk_r & ~hold) | (pend_r & ~clr_ch);
    assign blk_nxt = (blk_r | hold) & dlev;

    // Auto-repeat timer restarts on any press and stops on zero
    wire rep_on = klev && rep_ms != 6'h00;
    wire rep_hit = rep_on && tick && ({1'b0, rep_r} + 7'h01) >= {1'b0, rep_ms};
    assign rep_nxt = (!rep_on || krise || rep_hit) ? 6'h00 : (tick ? rep_r + 6'h01 : rep_r);

    // Keypad events: press, optional release, repeat
    wire kev = krise || (key_rel && kfall) || rep_hit;
    assign kpend_nxt = kev || (kpend_r && !kclr);

    // Read data; the clear register always reads zero
    // Unmapped word indices fall through to zero rather than erroring
    always_comb begin
        sel_rd = 16'h0000;
        for (int i = 0; i < NC; i++) begin
            if (hit_sel[i]) begin
                sel_rd = {10'h000, sel_r[i]};
            end
        end
    end

    wire [15:0] stat = {3'h0, dlev, 1'b0, klev, kpend_r, pend_r};
    wire [15:0] rd16 = hit_deb ? deb_r :
                       hit_lvl ? lvl_r :
                       hit_key ? key_r :
                       hit_stat ? stat :
                       hit_clr ? 16'h0000 : sel_rd;

    // Bus answer state: ack lasts one cycle
    always_comb begin
        case (st_r)
            gkid_pkg::GKID_WB_IDLE: st_nxt = acc ? gkid_pkg::GKID_WB_ACK : st_r;
            gkid_pkg::GKID_WB_ACK: st_nxt = gkid_pkg::GKID_WB_IDLE;
            default: st_nxt = gkid_pkg::GKID_WB_IDLE;
        endcase
    end

    // Bus slave and tick counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= gkid_pkg::GKID_WB_IDLE;
            dat_r <= 32'h0000_0000;
            tick_r <= 32'h0000_0000;
        end else if (ce_i) begin
            st_r <= st_nxt;
            if (acc) begin
                dat_r <= {16'h0000, rd16};
            end
            tick_r <= tick ? 32'h0000_0000 : tick_r + 32'h0000_0001;
        end
    end

    // Software-written control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deb_r <= gkid_pkg::REG_RST;
            lvl_r <= gkid_pkg::REG_RST;
            key_r <= gkid_pkg::REG_RST;
        end else if (wr) begin
            if (hit_deb) begin
                deb_r <= merge16(deb_r, wb_dat_i, wb_sel_i, gkid_pkg::DEB_MASK);
            end
            if (hit_lvl) begin
                lvl_r <= merge16(lvl_r, wb_dat_i, wb_sel_i, gkid_pkg::LVL_MASK);
            end
            if (hit_key) begin
                key_r <= merge16(key_r, wb_dat_i, wb_sel_i, gkid_pkg::KEY_MASK);
            end
        end
    end

    // Pin selectors, one per channel
    // Reserved selector bits are dropped at the write, so they read zero
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NC; i++) begin
            if (rst_i) begin
                sel_r[i] <= gkid_pkg::SEL_RST;
            end else if (wr && hit_sel[i]) begin
                sel_r[i] <= 6'(merge16({10'h000, sel_r[i]}, wb_dat_i, wb_sel_i,
                                       gkid_pkg::SEL_MASK));
            end
        end
    end

    // Interrupt state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= '0;
            blk_r <= '0;
            kpend_r <= 1'b0;
            rep_r <= 6'h00;
        end else if (ce_i) begin
            pend_r <= pend_nxt;
            blk_r <= blk_nxt;
            kpend_r <= kpend_nxt;
            rep_r <= rep_nxt;
        end
    end

    assign wb_ack_o = st_r == gkid_pkg::GKID_WB_ACK;
    assign wb_dat_o = dat_r;
    assign channel_irq_o = pend_r;
    assign keypad_interrupt_o = kpend_r;

    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    clr_reads_zero_a: assert property (
        acc && !wb_we_i && hit_clr |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("clear register did not read zero");
    ack_single_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chan_reraise_a: assert property (
        ce_i && dlev[0] && !blk_r[0] && !ch_wait[0] |=> pend_r[0])
        else $error("channel did not re-raise while active");
    wait_block_a: assert property (
        ce_i && clr_ch[0] && ch_wait[0] && dlev[0] && !drise[0]
        |=> !pend_r[0] ##1 (!pend_r[0] || !$past(blk_r[0])))
        else $error("channel raised before release");
    chan_polarity_a: assert property (
        ce_i && !deb_ch_on[0] && sel_r[0] == 6'h01 && $stable(sel_r[0])
        && $stable(ch_low[0]) && (pin_s[0] ^ ch_low[0]) |=> dlev[0])
        else $error("channel level does not follow polarity");
    release_irq_a: assert property (
        ce_i && kfall && key_rel |=> kpend_r)
        else $error("release interrupt missing");
    repeat_off_a: assert property (
        rep_ms == 6'h00 |-> !rep_hit && rep_nxt == 6'h00)
        else $error("repeat active with zero period");
    repeat_cause_a: assert property (
        rep_hit |-> tick && klev && rep_r + 6'h01 >= rep_ms)
        else $error("repeat fired off its period");
    key_enable_a: assert property (
        key_en == '0 |-> !kcond)
        else $error("disabled pins reached the keypad");
    kpend_set_a: assert property (
        ce_i && krise |=> kpend_r)
        else $error("keypad press not latched");
    ack_take_a: assert property (
        acc |=> wb_ack_o)
        else $error("taken request not answered next cycle");

    // Clears, selectors, keypad polarity and timing; an idle channel must not
    // come back from a clear, or software would see phantom events
    chan_clear_a: assert property (
        ce_i && clr_ch[0] && !dlev[0] |=> !pend_r[0])
        else $error("channel clear did not take");
    key_clear_a: assert property (
        ce_i && kclr && !kev |=> !kpend_r)
        else $error("keypad clear did not take");
    sel_none_a: assert property (
        (sel_r[0] == 6'h00 || sel_r[0] > 6'h20) |-> !chan_cond[0])
        else $error("unassigned selector produced a condition");
    key_polarity_a: assert property (
        (key_low ? |(key_en & ~pin_s[NK-1:0]) : |(key_en & pin_s[NK-1:0])) |-> kcond)
        else $error("keypad condition ignores polarity");
    key_deb_gate_a: assert property (
        ce_i && deb_key_on && deb_ms != 6'h00 && !tick |=> $stable(klev))
        else $error("keypad level moved without a tick");
    rep_restart_a: assert property (
        ce_i && krise |=> rep_r == 6'h00)
        else $error("repeat timer not restarted on press");

    cover property (rep_hit && kpend_r);
    cover property (clr_ch[0] && ch_wait[0] && dlev[0]);
    cover property (kfall && key_rel);
    cover property (wb_ack_o && hit_stat);
    cover property (kclr && kpend_r);
endmodule // gkid_irq_top

// file: design/gkid_pkg.sv
// Package: register map, field positions, reset values and timing
package gkid_pkg;
    // Printed register offsets, kept as register indices
    localparam logic [31:0] SEL0_IDX = 32'h5000_1400;
    localparam logic [31:0] DEB_IDX = 32'h5000_140c;
    localparam logic [31:0] CLR_IDX = 32'h5000_140e;
    localparam logic [31:0] LVL_IDX = 32'h5000_1410;
    localparam logic [31:0] KEY_IDX = 32'h5000_1412;
    localparam logic [31:0] STAT_IDX = 32'h5000_1420;
    // Word index seen on the bus: byte address bits 7:2
    localparam logic [5:0] SEL0_WI = SEL0_IDX[5:0];
    localparam logic [5:0] DEB_WI = DEB_IDX[5:0];
    localparam logic [5:0] CLR_WI = CLR_IDX[5:0];
    localparam logic [5:0] LVL_WI = LVL_IDX[5:0];
    localparam logic [5:0] KEY_WI = KEY_IDX[5:0];
    localparam logic [5:0] STAT_WI = STAT_IDX[5:0];
    // Field positions
    localparam int DEB_VAL_LSB = 0;
    localparam int DEB_CH_LSB = 8;
    localparam int DEB_KEY_BIT = 13;
    localparam int CLR_KEY_BIT = 5;
    localparam int LOW_LSB = 0;
    localparam int WAIT_LSB = 8;
    localparam int KEN_LSB = 0;
    localparam int REP_LSB = 8;
    localparam int KLOW_BIT = 14;
    localparam int REL_BIT = 15;
    // Writable bits and values after reset
    localparam logic [15:0] DEB_MASK = 16'h3f3f;
    localparam logic [15:0] LVL_MASK = 16'h1f1f;
    localparam logic [15:0] KEY_MASK = 16'hffff;
    localparam logic [15:0] SEL_MASK = 16'h003f;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [5:0] SEL_RST = 6'h00;
    // Sizes
    localparam int N_CH = 5;
    localparam int N_PINS = 32;
    localparam int N_KEYS = 8;
    localparam int MS_W = 6;
    // Millisecond tick derived from the 100 MHz clock
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 10;
    localparam int TICK_CYCLES = MS_NS / CLK_NS;
    // Bus answer state
    typedef enum logic [0:0] {
        GKID_WB_IDLE = 1'b0,
        GKID_WB_ACK = 1'b1
    } gkid_wb_t;
endpackage

// file: design/gkid_sync.sv
// Two-stage synchroniser for the port pins
`timescale 1ns/1ns
module gkid_sync #(
    parameter int W = gkid_pkg::N_PINS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    // Only the second stage is read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
        end else if (ce_i) begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end

    assign q_o = s2_r;
endmodule // gkid_sync

// file: sim/gkid_key_model.sv
// Behavioural key and button model driving the port pins
`timescale 1ns/1ns
module gkid_key_model (
    input wire logic clk_i,
    input wire logic bounce_i,
    input wire logic [31:0] want_i,
    output logic [31:0] pin_o
);
    logic [2:0] chatter_r = 3'h0;
    logic [31:0] old_r = 32'h0;
    initial pin_o = 32'h0;
    // Contacts chatter between old and new level, shorter than one tick,
    // so a debouncer that does not restart its count fires too early
    always @(posedge clk_i) begin
        if (chatter_r != 3'h0) begin
            chatter_r <= chatter_r - 3'h1;
            pin_o <= chatter_r[0] ? want_i : old_r;
        end else if (bounce_i && want_i != pin_o) begin
            chatter_r <= 3'h6;
            old_r <= pin_o;
        end else begin
            pin_o <= want_i;
        end
    end
endmodule // gkid_key_model

// file: sim/tb_gkid_irq_top.sv
// Self-checking bench for the pin and keypad interrupt block
`timescale 1ns/1ns
module tb_gkid_irq_top;
    localparam int TICK = 10;
    localparam logic [7:0] a_deb = 8'h30;
    localparam logic [7:0] a_clr = 8'h38;
    localparam logic [7:0] a_lvl = 8'h40;
    localparam logic [7:0] a_key = 8'h48;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [31:0] pin_i;
    logic [4:0] channel_irq_o;
    logic keypad_interrupt_o;
    logic [31:0] want_r = 32'h0;
    logic bounce_r = 1'b0;
    int num_errors = 0;
    int comparisons = 0;

    always #5 clk_i = ~clk_i;

    gkid_irq_top #(.TICK_CYCLES(TICK)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
        .channel_irq_o(channel_irq_o), .keypad_interrupt_o(keypad_interrupt_o)
    );
    gkid_key_model keys (.clk_i(clk_i), .bounce_i(bounce_r), .want_i(want_r), .pin_o(pin_i));

    task automatic give_verdict;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                            output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            give_verdict;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] x;
        wb_cycle(1'b1, a, {16'h0, d}, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        wb_cycle(1'b0, a, 32'h0, x);
        chk_val(what, exp, x);
    endtask

    task automatic set_pins(input logic [31:0] v);
        @(posedge clk_i);
        want_r <= v;
    endtask

    // Watch a pending flag (index 5 is the keypad) for at most lim cycles
    task automatic expect_flag(input string what, input int idx, input int lim, input logic exp);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && hit !== 1'b1; i++) begin
            @(posedge clk_i);
            hit = (idx == 5) ? keypad_interrupt_o : channel_irq_o[idx];
        end
        chk_flag(what, exp, hit);
    endtask

    // Reset values, writable bits, write-only clear and an unmapped place
    task automatic s_regs;
        rd_chk("deb rst", a_deb, 32'h0);
        rd_chk("lvl rst", a_lvl, 32'h0);
        rd_chk("key rst", a_key, 32'h0);
        wr(a_deb, 16'hffff);
        rd_chk("deb rw", a_deb, 32'h3f3f);
        wr(a_lvl, 16'hffff);
        rd_chk("lvl rw", a_lvl, 32'h1f1f);
        wr(a_deb, 16'h0000);
        wr(a_key, 16'hffff);
        rd_chk("key rw", a_key, 32'hffff);
        expect_flag("kp low", 5, 30, 1'b1);
        wr(a_key, 16'h0000);
        repeat (10) @(posedge clk_i);
        wr(a_clr, 16'h003f);
        rd_chk("clr reads 0", a_clr, 32'h0);
        expect_flag("kp cleared", 5, 10, 1'b0);
        wr(8'hfc, 16'hffff);
        rd_chk("unmapped", 8'hfc, 32'h0);
        wr(a_lvl, 16'h0000);
    endtask

    // Channel 0 on pin 0: selector, polarity, both clear modes and debounce
    task automatic s_chan;
        set_pins(32'h1);
        expect_flag("ch0 no sel", 0, 12, 1'b0);
        wr(8'h00, 16'h0021);
        rd_chk("ch0 sel rw", 8'h00, 32'h21);
        expect_flag("ch0 bad sel", 0, 12, 1'b0);
        wr(8'h00, 16'h0001);
        expect_flag("ch0 high", 0, 12, 1'b1);
        wr(a_clr, 16'h0001);
        expect_flag("ch0 level", 0, 6, 1'b1);
        wr(a_lvl, 16'h0100);
        wr(a_clr, 16'h0001);
        expect_flag("ch0 held", 0, 20, 1'b0);
        set_pins(32'h0);
        expect_flag("ch0 idle", 0, 12, 1'b0);
        set_pins(32'h1);
        expect_flag("ch0 rearm", 0, 12, 1'b1);
        wr(a_lvl, 16'h0001);
        wr(a_clr, 16'h0001);
        expect_flag("ch0 low off", 0, 12, 1'b0);
        wr(a_deb, 16'h0104);
        set_pins(32'h0);
        expect_flag("ch0 deb early", 0, 25, 1'b0);
        expect_flag("ch0 deb", 0, 30, 1'b1);
        rd_chk("status", 8'h80, 32'h0101);
    endtask

    // Keypad: pin enables, debounce with chatter, release and repeat
    task automatic s_keypad;
        wr(a_deb, 16'h2003);
        wr(a_key, 16'h8004);
        bounce_r <= 1'b1;
        set_pins(32'h2);
        expect_flag("kp pin off", 5, 50, 1'b0);
        set_pins(32'h4);
        expect_flag("kp early", 5, 22, 1'b0);
        expect_flag("kp deb", 5, 30, 1'b1);
        wr(a_clr, 16'h0020);
        expect_flag("kp no rep", 5, 60, 1'b0);
        set_pins(32'h0);
        expect_flag("kp release", 5, 55, 1'b1);
        bounce_r <= 1'b0;
        wr(a_deb, 16'h0000);
        wr(a_key, 16'h0404);
        wr(a_clr, 16'h0020);
        set_pins(32'h4);
        expect_flag("kp press", 5, 12, 1'b1);
        wr(a_clr, 16'h0020);
        expect_flag("kp rep early", 5, 15, 1'b0);
        expect_flag("kp repeat", 5, 35, 1'b1);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        give_verdict;
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs;
        s_chan;
        s_keypad;
        give_verdict;
    end
endmodule // tb_gkid_irq_top
